//--- rtl/asr_regs.vh
// Constants shared by the converter control block and its reset detector.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// Serial reset detector: run length of ones on the data input
`define ASR_ONES_RUN        6'h28
`define ASR_ONES_LAST       6'h27
`define ASR_ONES_ZERO       6'h00

// Access hold-off after power-up or serial reset
`define ASR_WAIT_US         500
`define ASR_CLK_MHZ         100

// Settling, in filter output periods
`define ASR_SETTLE_SINC4    3'h4
`define ASR_SETTLE_SINC3    3'h3
`define ASR_SETTLE_FAST     3'h1
`define ASR_SETTLE_ZERO     3'h0
`define ASR_SETTLE_STEP     3'h1

// Result clamp when the reference is missing
`define ASR_ALL_ONES        24'hFFFFFF

// Configuration defaults
`define ASR_BURN_DEF        1'b0
`define ASR_REFERENCE_PAIR_SELECT_DEF      1'b0
`define ASR_REFCHK_DEF      1'b0
`define ASR_TEMP_DEF        1'b0
`define ASR_SINC4_DEF       1'b1
`define ASR_ZLAT_DEF        1'b0
`define ASR_CHOP_DEF        1'b0
`define ASR_SYNCCONV_DEF    1'b0
`define ASR_GPO_DEF         1'b0

// Calibration coefficient defaults
`define ASR_OFFSET_DEF      24'h800000
`define ASR_FULL_DEF        24'h500000
`define ASR_DATA_DEF        24'h000000

// Reset hold-off counter
`define ASR_WAIT_ZERO       16'h0000
`define ASR_WAIT_STEP       16'h0001

// Temperature sensor transfer, bipolar mode
`define ASR_TEMP_ZERO_K     24'h800000
`define ASR_TEMP_PER_DEGC   2815

`endif

//--- rtl/asr_ones_det.v
// Serial-input reset detector: flags an unbroken run of ones.
// Assumes bit strobes synchronous to the clock, one per sampled data bit.
`timescale 1ns/1ps
`include "asr_regs.vh"

module asr_ones_det (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       en_i,
  input  wire       bit_valid_i,
  input  wire       bit_i,
  output reg        run_reset_o
);

  reg [5:0] count_q;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_q     <= `ASR_ONES_ZERO;
      run_reset_o <= 1'b0;
    end
    else if (en_i)
    begin
      run_reset_o <= 1'b0;
      if (bit_valid_i)
      begin
        if (!bit_i)
          count_q <= `ASR_ONES_ZERO;
        else if (count_q == `ASR_ONES_LAST)
        begin
          count_q     <= `ASR_ONES_ZERO;
          run_reset_o <= 1'b1;
        end
        else
          count_q <= count_q + 6'h01;
      end
    end
  end

endmodule // asr_ones_det

//--- rtl/asr_ctrl.v
// Control and supervision around a sigma-delta converter core: resets,
// sync and sync-triggered conversion, reference select and check, burnout
// and temperature sensor routing.
// Assumes all inputs synchronous to REF_CLK_I; the analog core supplies
// reference comparator levels, filter words and calibration results.
//
// What this block does
// - Both burnout generators follow one enable bit together.
// - Select bit 1 uses reference pair two and disables its GPO function.
// - Reference checking runs only while its enable bit is 1.
// - Missing-reference flag sets on reference below 0.3 V or open input.
// - Normal results are forced to all ones while reference is missing.
// - Missing reference during calibration blocks coefficient update and sets error.
// - Forty consecutive ones on data input fully reset the block.
// - Power-up performs the same full reset.
// - Sync falling edge resets filter and modulator, holding while low; setup kept.
// - After sync rises, release on next master clock falling edge.
// - Sync conversion mode: start on rise, settle fully, ready falls.
// - Sinc4 without zero latency or chop needs four output periods.
// - Temperature select bit 1 routes the sensor to the converter input.
// - Bipolar sensor code is 0x800000 at 0 K, about 2815 codes/degC.
// - Ready pin goes low when a new result is available.
`timescale 1ns/1ps
`include "asr_regs.vh"

module asr_ctrl #(
  parameter integer RESET_WAIT_CYC = `ASR_WAIT_US * `ASR_CLK_MHZ
) (
  input  wire        REF_CLK_I,
  input  wire        NRST_I,
  input  wire        CLK_EN_I,
  input  wire        SDI_VALID_I,
  input  wire        SDI_I,
  input  wire        SYNC_N_I,
  input  wire        MCLK_I,
  input  wire        CFG_WR_I,
  input  wire        CFG_BURNOUT_EN_I,
  input  wire        CFG_REFERENCE_PAIR_SELECT_I,
  input  wire        CFG_REFERENCE_CHECK_ENABLE_I,
  input  wire        CFG_TEMP_SENSOR_SELECT_I,
  input  wire        CFG_SINC4_I,
  input  wire        CFG_ZERO_LATENCY_I,
  input  wire        CFG_CHOP_I,
  input  wire        CFG_SYNC_CONVERT_I,
  input  wire        CFG_GPO_EN_I,
  input  wire        REF_ONE_LOW_I,
  input  wire        REF_ONE_OPEN_I,
  input  wire        REF_TWO_LOW_I,
  input  wire        REF_TWO_OPEN_I,
  input  wire        RAW_VALID_I,
  input  wire [23:0] RAW_DATA_I,
  input  wire        DATA_READ_I,
  input  wire        CAL_START_I,
  input  wire        CAL_FULL_SCALE_I,
  input  wire        CAL_DONE_I,
  input  wire [23:0] CAL_RESULT_I,
  output wire        BURN_SOURCE_EN_O,
  output wire        BURN_SINK_EN_O,
  output wire        REFERENCE_PAIR_SELECT_O,
  output wire        GPO_PINS_EN_O,
  output wire        TEMP_SENSOR_SELECT_O,
  output wire        MISSING_REFERENCE_FLAG_O,
  output wire        CAL_ERROR_O,
  output wire        FILTER_RST_O,
  output wire        RDY_N_O,
  output wire [23:0] DATA_O,
  output wire [23:0] OFFSET_COEF_O,
  output wire [23:0] FULL_COEF_O,
  output wire        RESET_BUSY_O
);

  localparam [1:0] ST_RUN    = 2'h0;
  localparam [1:0] ST_HOLD   = 2'h1;
  localparam [1:0] ST_ARM    = 2'h2;
  localparam [1:0] ST_SETTLE = 2'h3;

  localparam [31:0] WAIT_LAST = RESET_WAIT_CYC - 1;

  // Settling length in output periods for the chosen filter setup
  function [2:0] settle_len;
    input sinc4;
    input zlat;
    input chop;
    begin
      if (zlat || chop)
        settle_len = `ASR_SETTLE_FAST;
      else if (sinc4)
        settle_len = `ASR_SETTLE_SINC4;
      else
        settle_len = `ASR_SETTLE_SINC3;
    end
  endfunction

  wire        soft_rst;
  reg         burn_q;
  reg         reference_pair_select_q;
  reg         refchk_q;
  reg         temp_q;
  reg         sinc4_q;
  reg         zlat_q;
  reg         chop_q;
  reg         syncconv_q;
  reg         gpo_q;
  reg         missing_reference_flag_q;
  reg         err_q;
  reg         cal_act_q;
  reg         cal_full_q;
  reg         cal_bad_q;
  reg  [23:0] data_q;
  reg  [23:0] offset_q;
  reg  [23:0] full_q;
  reg         rdy_n_q;
  reg  [1:0]  st_q;
  reg  [2:0]  settle_q;
  reg         sync_prev_q;
  reg         mclk_prev_q;
  reg         filt_rst_q;
  reg  [15:0] wait_q;
  reg         busy_q;

  wire ref_low  = reference_pair_select_q ? REF_TWO_LOW_I  : REF_ONE_LOW_I;
  wire ref_open = reference_pair_select_q ? REF_TWO_OPEN_I : REF_ONE_OPEN_I;
  wire sync_fall = sync_prev_q && !SYNC_N_I;
  wire mclk_fall = mclk_prev_q && !MCLK_I;
  wire [2:0] settle_need = settle_len(sinc4_q, zlat_q, chop_q);
  wire settle_end = RAW_VALID_I && (settle_q == settle_need - `ASR_SETTLE_STEP);
  wire [23:0] result = missing_reference_flag_q ? `ASR_ALL_ONES : RAW_DATA_I;
  wire cal_blocked = cal_bad_q || missing_reference_flag_q;

  asr_ones_det u_ones_det (
    .clk_i       (REF_CLK_I),
    .nrst_i      (NRST_I),
    .en_i        (CLK_EN_I),
    .bit_valid_i (SDI_VALID_I),
    .bit_i       (SDI_I),
    .run_reset_o (soft_rst)
  );

  // Setup registers; only a full reset returns them to defaults
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      burn_q     <= `ASR_BURN_DEF;
      reference_pair_select_q   <= `ASR_REFERENCE_PAIR_SELECT_DEF;
      refchk_q   <= `ASR_REFCHK_DEF;
      temp_q     <= `ASR_TEMP_DEF;
      sinc4_q    <= `ASR_SINC4_DEF;
      zlat_q     <= `ASR_ZLAT_DEF;
      chop_q     <= `ASR_CHOP_DEF;
      syncconv_q <= `ASR_SYNCCONV_DEF;
      gpo_q      <= `ASR_GPO_DEF;
    end
    else if (CLK_EN_I)
    begin
      if (soft_rst)
      begin
        burn_q     <= `ASR_BURN_DEF;
        reference_pair_select_q   <= `ASR_REFERENCE_PAIR_SELECT_DEF;
        refchk_q   <= `ASR_REFCHK_DEF;
        temp_q     <= `ASR_TEMP_DEF;
        sinc4_q    <= `ASR_SINC4_DEF;
        zlat_q     <= `ASR_ZLAT_DEF;
        chop_q     <= `ASR_CHOP_DEF;
        syncconv_q <= `ASR_SYNCCONV_DEF;
        gpo_q      <= `ASR_GPO_DEF;
      end
      else if (CFG_WR_I)
      begin
        burn_q     <= CFG_BURNOUT_EN_I;
        reference_pair_select_q   <= CFG_REFERENCE_PAIR_SELECT_I;
        refchk_q   <= CFG_REFERENCE_CHECK_ENABLE_I;
        temp_q     <= CFG_TEMP_SENSOR_SELECT_I;
        sinc4_q    <= CFG_SINC4_I;
        zlat_q     <= CFG_ZERO_LATENCY_I;
        chop_q     <= CFG_CHOP_I;
        syncconv_q <= CFG_SYNC_CONVERT_I;
        gpo_q      <= CFG_GPO_EN_I;
      end
    end
  end

  // Reference check and calibration supervision
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      missing_reference_flag_q    <= 1'b0;
      err_q      <= 1'b0;
      cal_act_q  <= 1'b0;
      cal_full_q <= 1'b0;
      cal_bad_q  <= 1'b0;
      offset_q   <= `ASR_OFFSET_DEF;
      full_q     <= `ASR_FULL_DEF;
    end
    else if (CLK_EN_I)
    begin
      if (soft_rst)
      begin
        missing_reference_flag_q    <= 1'b0;
        err_q      <= 1'b0;
        cal_act_q  <= 1'b0;
        cal_full_q <= 1'b0;
        cal_bad_q  <= 1'b0;
        offset_q   <= `ASR_OFFSET_DEF;
        full_q     <= `ASR_FULL_DEF;
      end
      else
      begin
        // Live level, not sticky: follows the comparators while enabled
        missing_reference_flag_q <= refchk_q && (ref_low || ref_open);
        if (CAL_START_I)
        begin
          cal_act_q  <= 1'b1;
          cal_full_q <= CAL_FULL_SCALE_I;
          cal_bad_q  <= 1'b0;
        end
        else if (cal_act_q && CAL_DONE_I)
        begin
          cal_act_q <= 1'b0;
          cal_bad_q <= 1'b0;
          if (!cal_blocked && cal_full_q)
            full_q <= CAL_RESULT_I;
          else if (!cal_blocked)
            offset_q <= CAL_RESULT_I;
        end
        else if (cal_act_q && missing_reference_flag_q)
          cal_bad_q <= 1'b1;
        // A failed calibration's set wins over the clear at a new start
        if (cal_act_q && CAL_DONE_I && cal_blocked)
          err_q <= 1'b1;
        else if (CAL_START_I)
          err_q <= 1'b0;
      end
    end
  end

  // Sync handling, filter reset and result delivery
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      st_q        <= ST_RUN;
      settle_q    <= `ASR_SETTLE_ZERO;
      sync_prev_q <= 1'b1;
      mclk_prev_q <= 1'b0;
      filt_rst_q  <= 1'b1;
      rdy_n_q     <= 1'b1;
      data_q      <= `ASR_DATA_DEF;
    end
    else if (CLK_EN_I)
    begin
      sync_prev_q <= SYNC_N_I;
      mclk_prev_q <= MCLK_I;
      if (soft_rst)
      begin
        st_q       <= ST_RUN;
        settle_q   <= `ASR_SETTLE_ZERO;
        filt_rst_q <= 1'b1;
        rdy_n_q    <= 1'b1;
        data_q     <= `ASR_DATA_DEF;
      end
      else
      begin
        filt_rst_q <= 1'b0;
        case (st_q)
          ST_RUN:
          begin
            if (sync_fall)
            begin
              st_q       <= ST_HOLD;
              filt_rst_q <= 1'b1;
              rdy_n_q    <= 1'b1;
            end
            else if (RAW_VALID_I && !syncconv_q)
            begin
              data_q  <= result;
              rdy_n_q <= 1'b0;
            end
            else if (DATA_READ_I)
              rdy_n_q <= 1'b1;
          end
          ST_HOLD:
          begin
            filt_rst_q <= 1'b1;
            if (SYNC_N_I)
              st_q <= ST_ARM;
          end
          ST_ARM:
          begin
            // Still in reset until the master clock falls
            if (!SYNC_N_I)
            begin
              st_q       <= ST_HOLD;
              filt_rst_q <= 1'b1;
            end
            else if (mclk_fall)
            begin
              settle_q <= `ASR_SETTLE_ZERO;
              st_q     <= syncconv_q ? ST_SETTLE : ST_RUN;
            end
            else
              filt_rst_q <= 1'b1;
          end
          ST_SETTLE:
          begin
            if (sync_fall)
            begin
              st_q       <= ST_HOLD;
              filt_rst_q <= 1'b1;
              rdy_n_q    <= 1'b1;
            end
            else if (settle_end)
            begin
              data_q  <= result;
              rdy_n_q <= 1'b0;
              st_q    <= ST_RUN;
            end
            else
            begin
              if (RAW_VALID_I)
                settle_q <= settle_q + `ASR_SETTLE_STEP;
              if (DATA_READ_I)
                rdy_n_q <= 1'b1;
            end
          end
          default:
            st_q <= ST_RUN;
        endcase
      end
    end
  end

  // Access hold-off after power-up or serial reset
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wait_q <= `ASR_WAIT_ZERO;
      busy_q <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      if (soft_rst)
      begin
        wait_q <= `ASR_WAIT_ZERO;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (wait_q == WAIT_LAST[15:0])
          busy_q <= 1'b0;
        else
          wait_q <= wait_q + `ASR_WAIT_STEP;
      end
    end
  end

  assign BURN_SOURCE_EN_O         = burn_q;
  assign BURN_SINK_EN_O           = burn_q;
  assign REFERENCE_PAIR_SELECT_O  = reference_pair_select_q;
  assign GPO_PINS_EN_O            = gpo_q && !reference_pair_select_q;
  // Sensor code scaling is analog; only the routing is decided here
  assign TEMP_SENSOR_SELECT_O     = temp_q;
  assign MISSING_REFERENCE_FLAG_O = missing_reference_flag_q;
  assign CAL_ERROR_O              = err_q;
  assign FILTER_RST_O             = filt_rst_q;
  assign RDY_N_O                  = rdy_n_q;
  assign DATA_O                   = data_q;
  assign OFFSET_COEF_O            = offset_q;
  assign FULL_COEF_O              = full_q;
  assign RESET_BUSY_O             = busy_q;

endmodule // asr_ctrl

//--- verification/asr_ctrl_properties.sv
// Concurrent checks on the asr_ctrl ports, bound into every instance.
// Assumes every port is synchronous to REF_CLK_I and NRST_I resets all.
`timescale 1ns/1ps

module asr_ctrl_props #(
  parameter integer RESET_WAIT_CYC = 50000
) (
  input wire        REF_CLK_I,
  input wire        NRST_I,
  input wire        SDI_VALID_I,
  input wire        SDI_I,
  input wire        SYNC_N_I,
  input wire        MCLK_I,
  input wire        REF_ONE_LOW_I,
  input wire        REF_ONE_OPEN_I,
  input wire        REF_TWO_LOW_I,
  input wire        REF_TWO_OPEN_I,
  input wire        RAW_VALID_I,
  input wire        CAL_DONE_I,
  input wire        BURN_SOURCE_EN_O,
  input wire        BURN_SINK_EN_O,
  input wire        REFERENCE_PAIR_SELECT_O,
  input wire        GPO_PINS_EN_O,
  input wire        TEMP_SENSOR_SELECT_O,
  input wire        MISSING_REFERENCE_FLAG_O,
  input wire        FILTER_RST_O,
  input wire        RDY_N_O,
  input wire [23:0] DATA_O,
  input wire [23:0] OFFSET_COEF_O,
  input wire [23:0] FULL_COEF_O,
  input wire        RESET_BUSY_O
);
  reg  [5:0] ones_q;
  reg  [2:0] hit_q;
  wire       hit = SDI_VALID_I && SDI_I && (ones_q == 6'h27);

  // Own copy of the run counter, so a miscount shows as a wrong reset
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ones_q <= 6'h00;
      hit_q  <= 3'h0;
    end
    else
    begin
      hit_q <= {hit_q[1:0], hit};
      if (SDI_VALID_I)
        ones_q <= (!SDI_I || hit) ? 6'h00 : ones_q + 6'h01;
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  a_burn_pair_equal: assert property (BURN_SOURCE_EN_O == BURN_SINK_EN_O)
    else $error("burnout generators differ");
  a_gpo_reference_pair_select_off: assert property (REFERENCE_PAIR_SELECT_O |-> !GPO_PINS_EN_O)
    else $error("gpo pins driven while pair two selected");
  a_flag_has_cause: assert property (MISSING_REFERENCE_FLAG_O |-> $past(REFERENCE_PAIR_SELECT_O ?
    (REF_TWO_LOW_I || REF_TWO_OPEN_I) : (REF_ONE_LOW_I || REF_ONE_OPEN_I)))
    else $error("missing reference flag without cause");
  a_clamp_all_ones: assert property (RAW_VALID_I && MISSING_REFERENCE_FLAG_O ##1 $fell(RDY_N_O)
    |-> DATA_O == 24'hFFFFFF)
    else $error("result not clamped");
  a_cal_blocked: assert property (CAL_DONE_I && MISSING_REFERENCE_FLAG_O
    |=> $stable(OFFSET_COEF_O) && $stable(FULL_COEF_O))
    else $error("coefficient updated without reference");
  a_serial_reset_done: assert property (hit |-> ##[2:3] (RESET_BUSY_O && FILTER_RST_O && RDY_N_O
    && !TEMP_SENSOR_SELECT_O && OFFSET_COEF_O == 24'h800000 && FULL_COEF_O == 24'h500000))
    else $error("serial reset incomplete");
  a_reset_has_cause: assert property ($rose(RESET_BUSY_O) |-> hit_q != 3'h0)
    else $error("reset without forty ones");
  a_sync_hold_low: assert property (!SYNC_N_I ##1 !SYNC_N_I |-> FILTER_RST_O)
    else $error("filter not held in sync");
  a_release_on_fall: assert property ($fell(FILTER_RST_O) && !RESET_BUSY_O |-> $past(SYNC_N_I)
    && (($past(MCLK_I, 2) && !$past(MCLK_I)) || ($past(MCLK_I, 3) && !$past(MCLK_I, 2))))
    else $error("filter released off master clock fall");
  a_sync_drops_ready: assert property ($fell(SYNC_N_I) |=> RDY_N_O)
    else $error("ready kept through sync");
endmodule // asr_ctrl_props

bind asr_ctrl asr_ctrl_props #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) u_props (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .SDI_VALID_I(SDI_VALID_I), .SDI_I(SDI_I),
  .SYNC_N_I(SYNC_N_I), .MCLK_I(MCLK_I), .REF_ONE_LOW_I(REF_ONE_LOW_I), .REF_ONE_OPEN_I(REF_ONE_OPEN_I),
  .REF_TWO_LOW_I(REF_TWO_LOW_I), .REF_TWO_OPEN_I(REF_TWO_OPEN_I), .RAW_VALID_I(RAW_VALID_I),
  .CAL_DONE_I(CAL_DONE_I), .BURN_SOURCE_EN_O(BURN_SOURCE_EN_O), .BURN_SINK_EN_O(BURN_SINK_EN_O),
  .REFERENCE_PAIR_SELECT_O(REFERENCE_PAIR_SELECT_O), .GPO_PINS_EN_O(GPO_PINS_EN_O),
  .TEMP_SENSOR_SELECT_O(TEMP_SENSOR_SELECT_O), .MISSING_REFERENCE_FLAG_O(MISSING_REFERENCE_FLAG_O),
  .FILTER_RST_O(FILTER_RST_O), .RDY_N_O(RDY_N_O), .DATA_O(DATA_O), .OFFSET_COEF_O(OFFSET_COEF_O),
  .FULL_COEF_O(FULL_COEF_O), .RESET_BUSY_O(RESET_BUSY_O));

//--- verification/asr_host_model.sv
// Host side model: serial data bits, the sync pin and a free master clock.
// Assumes the block samples everything on the rising edge of clk_i.
`timescale 1ns/1ps

module asr_host_model (
  input  wire clk_i,
  output reg  sdi_valid_o,
  output reg  sdi_o,
  output reg  sync_n_o,
  output wire mclk_o
);
  reg     [1:0] div_q;
  integer       k;

  assign mclk_o = div_q[1];

  initial
  begin
    sdi_valid_o = 1'b0;
    sdi_o       = 1'b0;
    sync_n_o    = 1'b1;
    div_q       = 2'h0;
  end

  always @(negedge clk_i)
    div_q <= div_q + 2'h1;

  task send_bits(input integer n, input reg b);
    for (k = 0; k < n; k = k + 1)
    begin
      @(negedge clk_i);
      sdi_valid_o = 1'b1;
      sdi_o       = b;
    end
    @(negedge clk_i);
    sdi_valid_o = 1'b0;
    sdi_o       = ~b;
  endtask

  task sync_pulse(input integer n);
    @(negedge clk_i);
    sync_n_o = 1'b0;
    repeat (4 * n) @(negedge clk_i);
    // Rise together with the master clock so several parts start alike
    while (div_q != 2'h1)
      @(negedge clk_i);
    sync_n_o <= 1'b1;
  endtask
endmodule // asr_host_model

//--- verification/asr_ctrl_tb_top.sv
// Self-checking bench for asr_ctrl with the host model on the serial side.
// Assumes a 100 MHz clock; the hold-off count is shortened for speed.
`timescale 1ns/1ps

module asr_ctrl_tb_top;
  localparam integer WAIT_CYC = 20;
  reg         clk, nrst, cfg_wr, rl1, ro1, rl2, ro2, raw_v, rd, cal_s, cal_f, cal_d;
  reg         cen;
  reg  [8:0]  cfgv;
  reg  [23:0] raw_d, cal_r;
  wire        sdi_v, sdi, sync_n, mclk, burn_src, burn_snk, reference_pair_select, gpo, temp, missing_reference_flag, cal_err, frst, rdy_n, busy;
  wire [23:0] dout, offs, fulls;
  integer     error_cnt, n_tests, cyc;

  asr_host_model host (.clk_i(clk), .sdi_valid_o(sdi_v), .sdi_o(sdi), .sync_n_o(sync_n), .mclk_o(mclk));

  asr_ctrl #(.RESET_WAIT_CYC(WAIT_CYC)) dut (
    .REF_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(cen), .SDI_VALID_I(sdi_v), .SDI_I(sdi), .SYNC_N_I(sync_n),
    .MCLK_I(mclk), .CFG_WR_I(cfg_wr), .CFG_BURNOUT_EN_I(cfgv[8]), .CFG_REFERENCE_PAIR_SELECT_I(cfgv[7]),
    .CFG_REFERENCE_CHECK_ENABLE_I(cfgv[6]), .CFG_TEMP_SENSOR_SELECT_I(cfgv[5]), .CFG_SINC4_I(cfgv[4]),
    .CFG_ZERO_LATENCY_I(cfgv[3]), .CFG_CHOP_I(cfgv[2]), .CFG_SYNC_CONVERT_I(cfgv[1]), .CFG_GPO_EN_I(cfgv[0]),
    .REF_ONE_LOW_I(rl1), .REF_ONE_OPEN_I(ro1), .REF_TWO_LOW_I(rl2), .REF_TWO_OPEN_I(ro2),
    .RAW_VALID_I(raw_v), .RAW_DATA_I(raw_d), .DATA_READ_I(rd), .CAL_START_I(cal_s),
    .CAL_FULL_SCALE_I(cal_f), .CAL_DONE_I(cal_d), .CAL_RESULT_I(cal_r), .BURN_SOURCE_EN_O(burn_src),
    .BURN_SINK_EN_O(burn_snk), .REFERENCE_PAIR_SELECT_O(reference_pair_select), .GPO_PINS_EN_O(gpo),
    .TEMP_SENSOR_SELECT_O(temp), .MISSING_REFERENCE_FLAG_O(missing_reference_flag), .CAL_ERROR_O(cal_err),
    .FILTER_RST_O(frst), .RDY_N_O(rdy_n), .DATA_O(dout), .OFFSET_COEF_O(offs), .FULL_COEF_O(fulls),
    .RESET_BUSY_O(busy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task finish_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole run needs about 400 cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end

  task chk1(input reg got, input reg exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chk24(input [23:0] got, input [23:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cfg_w(input [8:0] v);
    @(negedge clk);
    cfgv   = v;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  task word(input [23:0] d);
    @(negedge clk);
    raw_v = 1'b1;
    raw_d = d;
    @(negedge clk);
    raw_v = 1'b0;
    @(negedge clk);
  endtask

  task wait_busy;
    integer k;
    k = 0;
    while (busy !== 1'b0 && k < 100)
    begin
      @(negedge clk);
      k = k + 1;
    end
    chk1(busy, 1'b0);
  endtask

  task t_config;
    cfg_w(9'h1B1);
    chk1(burn_src, 1'b1);
    chk1(burn_snk, 1'b1);
    chk1(reference_pair_select, 1'b1);
    chk1(gpo, 1'b0);
    chk1(temp, 1'b1);
    cfg_w(9'h011);
    chk1(burn_snk, 1'b0);
    chk1(gpo, 1'b1);
    chk1(temp, 1'b0);
  endtask

  // Enable low: a write and a word must leave no trace
  task t_freeze;
    cen = 1'b0;
    cfg_w(9'h1B1);
    word(24'h654321);
    chk1(burn_src, 1'b0);
    chk1(rdy_n, 1'b1);
    chk24(dout, 24'h000000);
    cen = 1'b1;
  endtask

  task t_refchk;
    rl1 = 1'b1;
    cfg_w(9'h010);
    @(negedge clk);
    chk1(missing_reference_flag, 1'b0);
    cfg_w(9'h050);
    @(negedge clk);
    chk1(missing_reference_flag, 1'b1);
    word(24'h123456);
    chk24(dout, 24'hFFFFFF);
    chk1(rdy_n, 1'b0);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk1(rdy_n, 1'b1);
    rl1 = 1'b0;
    ro2 = 1'b1;
    repeat (2) @(negedge clk);
    chk1(missing_reference_flag, 1'b0);
    word(24'h123456);
    chk24(dout, 24'h123456);
    cfg_w(9'h0D0);
    @(negedge clk);
    chk1(missing_reference_flag, 1'b1);
    ro2 = 1'b0;
  endtask

  task cal(input reg full, input reg bad, input [23:0] r);
    @(negedge clk);
    cal_s = 1'b1;
    cal_f = full;
    @(negedge clk);
    cal_s = 1'b0;
    rl1   = bad;
    repeat (3) @(negedge clk);
    cal_d = 1'b1;
    cal_r = r;
    @(negedge clk);
    cal_d = 1'b0;
    rl1   = 1'b0;
    repeat (2) @(negedge clk);
    chk1(cal_err, bad);
  endtask

  task t_calib;
    cfg_w(9'h050);
    cal(1'b0, 1'b0, 24'h7FFF00);
    chk24(offs, 24'h7FFF00);
    cal(1'b1, 1'b1, 24'h123400);
    chk24(fulls, 24'h500000);
    cal(1'b1, 1'b0, 24'h4FFF00);
    chk24(fulls, 24'h4FFF00);
  endtask

  task t_sync(input [8:0] v, input integer n);
    integer k;
    cfg_w(v);
    host.sync_pulse(4);
    chk1(frst, 1'b1);
    chk1(temp, 1'b1);
    k = 0;
    while (frst !== 1'b0 && k < 50)
    begin
      @(negedge clk);
      k = k + 1;
    end
    chk1(frst, 1'b0);
    for (k = 1; k <= n; k = k + 1)
    begin
      word(24'hA50000 + k[23:0]);
      chk1(rdy_n, k != n);
    end
    chk24(dout, 24'hA50000 + n[23:0]);
  endtask

  task t_serial;
    host.send_bits(39, 1'b1);
    host.send_bits(1, 1'b0);
    host.send_bits(39, 1'b1);
    repeat (4) @(negedge clk);
    chk1(busy, 1'b0);
    host.send_bits(1, 1'b1);
    repeat (3) @(negedge clk);
    chk1(busy, 1'b1);
    chk1(temp, 1'b0);
    chk24(offs, 24'h800000);
    wait_busy;
  endtask

  initial
  begin
    nrst = 1'b0;
    cen = 1'b1;
    {cfg_wr, rl1, ro1, rl2, ro2, raw_v, rd, cal_s, cal_f, cal_d} = 10'h000;
    cfgv = 9'h010;
    raw_d = 24'h000000;
    cal_r = 24'h000000;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(negedge clk);
    chk1(frst, 1'b1);
    chk1(rdy_n, 1'b1);
    chk24(fulls, 24'h500000);
    nrst = 1'b1;
    wait_busy;
    t_config;
    t_freeze;
    t_refchk;
    t_calib;
    t_sync(9'h032, 4);
    t_sync(9'h022, 3);
    t_sync(9'h03A, 1);
    t_sync(9'h036, 1);
    t_sync(9'h030, 1);
    t_serial;
    finish_test;
  end
endmodule // asr_ctrl_tb_top
